// ===== hdl/sltab_regs.svh
`ifndef SLTAB_REGS_SVH
`define SLTAB_REGS_SVH
// Register byte addresses on APB
`define SLTAB_MC_CTRL_ADDR   12'h41C
`define SLTAB_MC_DATA_ADDR   12'h424
`define SLTAB_VLAN_E0_ADDR   12'h400
`define SLTAB_VLAN_E1_ADDR   12'h404
`define SLTAB_VLAN_E2_ADDR   12'h408
`define SLTAB_VLAN_IDX_ADDR  12'h40C
`define SLTAB_VLAN_CTL_ADDR  12'h410
`define SLTAB_VLAN_MODE_ADDR 12'h414
`define SLTAB_ACL_DATA_BASE  12'h600
`define SLTAB_ACL_BE_ADDR    12'h640
`define SLTAB_ACL_CTL_ADDR   12'h644
`define SLTAB_ACL_PORT_ADDR  12'h648
// Control field positions
`define SLTAB_MC_GO_BIT      31
`define SLTAB_MC_SEL_BIT     30
`define SLTAB_MC_RD_BIT      29
`define SLTAB_VLAN_START_BIT 7
`define SLTAB_VLAN_RD_BIT    0
`define SLTAB_ACL_WR_BIT     4
`define SLTAB_ACL_RDST_BIT   5
`define SLTAB_ACL_WRST_BIT   6
// Table geometry
`define SLTAB_MC_ENTRIES     48
`define SLTAB_MC_GROUPS      8
`define SLTAB_VLAN_ENTRIES   4096
`define SLTAB_ACL_ENTRIES    16
`define SLTAB_ACL_BYTES      16
`define SLTAB_NUM_PORTS      3
`define SLTAB_ACL_UNUSED_BE  3
// Operation length in clocks
`define SLTAB_OP_CYCLES      2
`endif

// ===== hdl/sltab_pkg.sv
package sltab_pkg;
   // VLAN entry layout, 29 bits
   typedef struct packed {
      logic       valid;
      logic       fwd_option;
      logic [2:0] priority_val;
      logic [2:0] spanning_tree_index;
      logic [6:0] filter_group_id;
      logic [6:0] untag_mask;
      logic [6:0] member_mask;
   } sltab_vlan_s;
   // APB request bundle
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } sltab_apb_s;
   typedef enum logic [1:0] {OP_IDLE, OP_BUSY, OP_DONE} sltab_op_e;
endpackage : sltab_pkg

// ===== hdl/sltab_top.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "sltab_regs.svh"
module sltab_top
   import sltab_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic                      vlan_mode_en,
   input  wire logic [11:0]          lookup_vid,
   output sltab_pkg::sltab_vlan_s    lookup_entry
);
   import sltab_pkg::*;

   // ***************************************************
   // Storage
   // ***************************************************
   sltab_vlan_s vlan_mem [`SLTAB_VLAN_ENTRIES];
   logic [2:0]  mc_group_q [`SLTAB_MC_GROUPS];
   logic [7:0]  acl_mem [`SLTAB_NUM_PORTS][`SLTAB_ACL_ENTRIES][`SLTAB_ACL_BYTES];

   // ***************************************************
   // Software visible registers
   // ***************************************************
   logic [5:0]  mc_idx_q;       // Multicast index
   logic        mc_sel_q;       // Table choice
   logic        mc_rd_q;        // Operation is a read
   logic        mc_go_q;        // Go/done bit
   logic [2:0]  mc_data_q;      // Port forward bits
   logic [1:0]  mc_attr_q;      // Bits 31:30, plain storage
   sltab_vlan_s vlan_data_q;    // Staged entry
   logic [11:0] vlan_idx_q;     // Entry index
   logic        vlan_rd_q;      // Read selected
   logic        vlan_go_q;      // Start bit
   logic [7:0]  acl_data_q [`SLTAB_ACL_BYTES];
   logic [15:0] acl_be_q;       // Byte enables
   logic [3:0]  acl_idx_q;      // Entry index
   logic [1:0]  acl_port_q;     // Which port's table
   logic        acl_wr_q;       // Operation is a write
   logic        acl_busy_q;     // Operation in flight
   logic        acl_rdok_q;     // Read status
   logic        acl_wrok_q;     // Write status
   logic        mode_q;         // VLAN lookup enable
   logic [1:0]  vcnt_q;         // VLAN op timer
   logic [1:0]  mcnt_q;         // Multicast op timer
   logic [1:0]  acnt_q;         // ACL op timer
   logic [31:0] rdata_q;
   logic        ready_q;
   logic        err_q;
   sltab_vlan_s look_q;

   // ***************************************************
   // APB decode
   // ***************************************************
   wire acc        = psel & penable & ~ready_q;   // Single-wait access
   wire wr_acc     = acc & pwrite;
   wire hit_mcc    = paddr == `SLTAB_MC_CTRL_ADDR;
   wire hit_mcd    = paddr == `SLTAB_MC_DATA_ADDR;
   wire hit_e0     = paddr == `SLTAB_VLAN_E0_ADDR;
   wire hit_e1     = paddr == `SLTAB_VLAN_E1_ADDR;
   wire hit_e2     = paddr == `SLTAB_VLAN_E2_ADDR;
   wire hit_vi     = paddr == `SLTAB_VLAN_IDX_ADDR;
   wire hit_vc     = paddr == `SLTAB_VLAN_CTL_ADDR;
   wire hit_mode   = paddr == `SLTAB_VLAN_MODE_ADDR;
   wire hit_ad     = paddr[11:6] == `SLTAB_ACL_DATA_BASE >> 6 && paddr[1:0] == 2'h0;
   wire [3:0] abyt = paddr[5:2];
   wire hit_be     = paddr == `SLTAB_ACL_BE_ADDR;
   wire hit_ac     = paddr == `SLTAB_ACL_CTL_ADDR;
   wire hit_ap     = paddr == `SLTAB_ACL_PORT_ADDR;
   wire any_hit    = hit_mcc | hit_mcd | hit_e0 | hit_e1 | hit_e2 | hit_vi | hit_vc | hit_mode
                     | hit_ad | hit_be | hit_ac | hit_ap;
   wire busy_any   = mc_go_q | vlan_go_q | acl_busy_q;
   // Index and data are frozen while an operation runs
   wire wr_ok      = wr_acc & ~busy_any;
   wire [2:0] mc_grp = mc_idx_q[5:3];

   // Read mux
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0;
      if (hit_mcc) rmux = {mc_go_q, mc_sel_q, mc_rd_q, 23'h0, 6'(mc_idx_q)};
      else if (hit_mcd) rmux = {mc_attr_q, 27'h0, mc_data_q};
      // Entry 0 layout: 15 valid, 14 option, 13:11 tree, 10:8 priority, 6:0 group
      else if (hit_e0) rmux = {16'h0, vlan_data_q.valid, vlan_data_q.fwd_option,
                                vlan_data_q.spanning_tree_index, vlan_data_q.priority_val,
                                1'b0, vlan_data_q.filter_group_id};
      else if (hit_e1) rmux = {25'h0, vlan_data_q.untag_mask};
      else if (hit_e2) rmux = {25'h0, vlan_data_q.member_mask};
      else if (hit_vi) rmux = {20'h0, vlan_idx_q};
      else if (hit_vc) rmux = {24'h0, vlan_go_q, 6'h0, vlan_rd_q};
      else if (hit_mode) rmux = {31'h0, mode_q};
      else if (hit_ad) rmux = {24'h0, acl_data_q[abyt]};
      else if (hit_be) rmux = {16'h0, acl_be_q};
      else if (hit_ac) rmux = {25'h0, acl_wrok_q, acl_rdok_q, acl_wr_q, acl_idx_q};
      else if (hit_ap) rmux = {30'h0, acl_port_q};
   end

   // ***************************************************
   // Bus response
   // ***************************************************
   // One wait state; unmapped addresses answer with pslverr
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ready_q <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ready_q <= acc;
         err_q   <= acc & ~any_hit;
         rdata_q <= (acc & ~pwrite) ? rmux : 32'h0;
      end
   end

   // ***************************************************
   // Multicast table engine
   // ***************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mc_idx_q  <= 6'h0;
         mc_sel_q  <= 1'b0;
         mc_rd_q   <= 1'b0;
         mc_go_q   <= 1'b0;
         mc_data_q <= 3'h0;
         mc_attr_q <= 2'h0;
         mcnt_q    <= 2'h0;
         for (int g = 0; g < `SLTAB_MC_GROUPS; g++) mc_group_q[g] <= 3'h7;
      end else if (mc_go_q) begin
         // Operation in flight
         if (mcnt_q == 2'(`SLTAB_OP_CYCLES - 1)) begin
            mc_go_q <= 1'b0;
            mcnt_q  <= 2'h0;
            if (mc_sel_q && mc_rd_q) mc_data_q <= mc_group_q[mc_grp];
            else if (mc_sel_q) mc_group_q[mc_grp] <= mc_data_q;
         end else begin
            mcnt_q <= mcnt_q + 2'h1;
         end
      end else if (wr_ok && hit_mcc) begin
         mc_idx_q <= pwdata[5:0];
         mc_sel_q <= pwdata[`SLTAB_MC_SEL_BIT];
         mc_rd_q  <= pwdata[`SLTAB_MC_RD_BIT];
         mc_go_q  <= pwdata[`SLTAB_MC_GO_BIT];
      end else if (wr_ok && hit_mcd) begin
         mc_data_q <= pwdata[2:0];
         mc_attr_q <= pwdata[31:30];
      end
   end

   // ***************************************************
   // VLAN table engine
   // ***************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vlan_data_q <= '0;
         vlan_idx_q  <= 12'h0;
         vlan_rd_q   <= 1'b0;
         vlan_go_q   <= 1'b0;
         vcnt_q      <= 2'h0;
         mode_q      <= 1'b0;
      end else begin
         if (wr_acc && hit_mode) mode_q <= pwdata[0];
         if (vlan_go_q) begin
            if (vcnt_q == 2'(`SLTAB_OP_CYCLES - 1)) begin
               vlan_go_q <= 1'b0;
               vcnt_q    <= 2'h0;
               if (vlan_rd_q) vlan_data_q <= vlan_mem[vlan_idx_q];
            end else begin
               vcnt_q <= vcnt_q + 2'h1;
            end
         end else if (wr_ok) begin
            if (hit_e0) begin
               vlan_data_q.valid               <= pwdata[15];
               vlan_data_q.fwd_option          <= pwdata[14];
               vlan_data_q.priority_val        <= pwdata[10:8];
               // Tree index kept apart from priority and group id bits
               vlan_data_q.spanning_tree_index <= pwdata[13:11];
               vlan_data_q.filter_group_id     <= pwdata[6:0];
            end
            if (hit_e1) vlan_data_q.untag_mask  <= {4'h0, pwdata[2:0]};
            if (hit_e2) vlan_data_q.member_mask <= {4'h0, pwdata[2:0]};
            if (hit_vi) vlan_idx_q <= pwdata[11:0];
            if (hit_vc) begin
               vlan_rd_q <= pwdata[`SLTAB_VLAN_RD_BIT];
               vlan_go_q <= pwdata[`SLTAB_VLAN_START_BIT];
            end
         end
      end
   end

   // Table array write has no reset
   always_ff @(posedge clk) begin
      if (vlan_go_q && !vlan_rd_q && vcnt_q == 2'(`SLTAB_OP_CYCLES - 1))
         vlan_mem[vlan_idx_q] <= vlan_data_q;
   end

   // ***************************************************
   // VLAN lookup port for the forwarding path
   // ***************************************************
   // Entry presented only while the mode is on; fid feeds the hash,
   // option steers membership use downstream
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) look_q <= '0;
      else if (mode_q) look_q <= vlan_mem[lookup_vid];
      else look_q <= '0;
   end

   // ***************************************************
   // ACL table engine
   // ***************************************************
   // Byte enable bit i selects data byte 15-i; byte C never stored
   wire [15:0] be_eff = acl_be_q & ~(16'h1 << `SLTAB_ACL_UNUSED_BE);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acl_be_q   <= 16'h0;
         acl_idx_q  <= 4'h0;
         acl_port_q <= 2'h0;
         acl_wr_q   <= 1'b0;
         acl_busy_q <= 1'b0;
         acl_rdok_q <= 1'b1;
         acl_wrok_q <= 1'b1;
         acnt_q     <= 2'h0;
         for (int b = 0; b < `SLTAB_ACL_BYTES; b++) acl_data_q[b] <= 8'h0;
      end else if (acl_busy_q) begin
         if (acnt_q == 2'(`SLTAB_OP_CYCLES - 1)) begin
            acl_busy_q <= 1'b0;
            acnt_q     <= 2'h0;
            if (acl_wr_q) acl_wrok_q <= 1'b1;
            else acl_rdok_q <= 1'b1;
            for (int b = 0; b < `SLTAB_ACL_BYTES; b++)
               if (!acl_wr_q && be_eff[15 - b])
                  acl_data_q[b] <= acl_mem[acl_port_q][acl_idx_q][b];
         end else begin
            acnt_q <= acnt_q + 2'h1;
         end
      end else if (wr_ok) begin
         // Fields of each byte kept as written: process, match, action, mask
         if (hit_ad) acl_data_q[abyt] <= pwdata[7:0];
         if (hit_be) acl_be_q <= pwdata[15:0];
         if (hit_ap && pwdata[1:0] < 2'(`SLTAB_NUM_PORTS)) acl_port_q <= pwdata[1:0];
         if (hit_ac) begin
            // A single index write launches the operation
            acl_idx_q  <= pwdata[3:0];
            acl_wr_q   <= pwdata[`SLTAB_ACL_WR_BIT];
            acl_busy_q <= 1'b1;
            acl_rdok_q <= pwdata[`SLTAB_ACL_WR_BIT];
            acl_wrok_q <= ~pwdata[`SLTAB_ACL_WR_BIT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (acl_busy_q && acl_wr_q && acnt_q == 2'(`SLTAB_OP_CYCLES - 1))
         for (int b = 0; b < `SLTAB_ACL_BYTES; b++)
            if (be_eff[15 - b]) acl_mem[acl_port_q][acl_idx_q][b] <= acl_data_q[b];
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign prdata       = rdata_q;
   assign pready       = ready_q;
   assign pslverr      = err_q;
   assign vlan_mode_en = mode_q;
   assign lookup_entry = look_q;

endmodule : sltab_top

// ===== sim/sltab_props.sv
`timescale 1ns/1ps
// ********************************
// Bus answer and lookup checks
// ********************************
module sltab_props
   import sltab_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   reset_n,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic                   vlan_mode_en,
   input wire logic [11:0]            lookup_vid,
   input wire sltab_pkg::sltab_vlan_s lookup_entry
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire acc = psel && penable;   // Access phase of a transfer
   // One wait state, then a single-cycle answer
   ready_after_access_a: assert property (acc && !pready |=> pready) else $error("no answer");
   ready_one_pulse_a: assert property (pready |=> !pready) else $error("answer too long");
   ready_has_cause_a: assert property (pready |-> $past(acc)) else $error("answer unasked");
   error_with_ready_a: assert property (pslverr |-> pready) else $error("error alone");
   error_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
   // Multicast data register never faults; its bits 29:3 read zero
   mc_data_ok_a: assert property (acc && !pready && paddr == 12'h424 |=> !pslverr) else $error("data fault");
   mc_upper_zero_a: assert property (acc && pready && !pwrite && paddr == 12'h424 |-> prdata[29:3] == 27'h0)
      else $error("upper bits set");
   // Mode only moves through its own register
   mode_write_a: assert property (acc && pready && pwrite && paddr == 12'h414 |=> vlan_mode_en == $past(pwdata[0]))
      else $error("mode not written");
   mode_hold_a: assert property (!(acc && pwrite && paddr == 12'h414) |=> $stable(vlan_mode_en))
      else $error("mode moved");
   lookup_off_zero_a: assert property (!vlan_mode_en |=> lookup_entry == '0) else $error("lookup while off");
   cover property (pslverr);
   cover property ($rose(vlan_mode_en));
   cover property (acc && pready && !pwrite && paddr == 12'h424);
endmodule : sltab_props

bind sltab_top sltab_props u_props (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .vlan_mode_en(vlan_mode_en), .lookup_vid(lookup_vid), .lookup_entry(lookup_entry));

// ===== sim/switch_lookup_table_access_test.sv
`timescale 1ns/1ps
module switch_lookup_table_access_test;
   import sltab_pkg::*;
   typedef struct {logic [31:0] x; logic [31:0] m; logic e;} sltab_note_s;
   logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, vlan_mode_en;
   logic [11:0] paddr, lookup_vid;
   logic [31:0] pwdata, prdata, rv, lfsr;
   sltab_vlan_s lookup_entry;
   sltab_note_s notes [$];      // Expected read results, oldest first
   sltab_note_s nt;
   int          err_count, check_count, cycles;
   logic [7:0]  acl [3][16];    // Expected ACL bytes per port
   logic [31:0] mc [6];
   logic [31:0] ve [4][3];
   logic [11:0] vlan_identifier [4];
   // Stored bits per ACL byte with match mode 10; byte C holds nothing
   localparam logic [7:0] BMSK [16] = '{8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                        8'hFF, 8'hFF, 8'hFF, 8'hE0, 8'h00, 8'h7F, 8'hFF, 8'hFF};
   sltab_top dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vlan_mode_en(vlan_mode_en),
      .lookup_vid(lookup_vid), .lookup_entry(lookup_entry));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ********************************
   // Helpers
   // ********************************
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
      return lfsr;
   endfunction : rnd
   task automatic check(input logic [32:0] s, input logic [32:0] x);
      check_count++;
      if (s !== x) begin
         err_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, s, x);
      end
   endtask : check
   task automatic results();
      if (err_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   // A zero mask marks a read whose data is not judged
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m, input logic e);
      notes.push_back('{x, m, e});
      apb(1'b0, a, 32'h0);
   endtask : rd
   // Bounded wait for a status bit; a stuck bit shows as a mismatch
   task automatic poll(input logic [11:0] a, input int b, input logic v);
      int n;
      n = 0;
      do begin
         rd(a, 32'h0, 32'h0, 1'b0);
         n++;
      end while (rv[b] !== v && n < 40);
      check(33'(rv[b]), 33'(v));
   endtask : poll
   // Read watcher takes the oldest note per answered read
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
         nt = notes.pop_front();
         if (nt.m != 32'h0) check({pslverr, prdata & nt.m}, {nt.e, nt.x & nt.m});
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         results();
      end
   end
   // ********************************
   // Scenarios
   // ********************************
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      lookup_vid = 12'h0;
      reset_n = 1'b0;
      lfsr = 32'h5CF7158E;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      rd(12'h414, 32'h0, 32'h1, 1'b0);
      rd(12'h7F0, 32'h0, 32'hFFFFFFFF, 1'b1);
      // Multicast: write one member in each of groups 0 to 5, read another member back
      for (int g = 0; g < 6; g++) begin
         mc[g] = rnd();
         wr(12'h424, mc[g]);
         wr(12'h41C, {3'b110, 23'h0, 3'(g), mc[g][30:28]});
         poll(12'h41C, 31, 1'b0);
      end
      for (int g = 0; g < 6; g++) begin
         wr(12'h41C, {3'b111, 23'h0, 3'(g), mc[g][27:25]});
         poll(12'h41C, 31, 1'b0);
         rd(12'h424, mc[g], 32'h7, 1'b0);
      end
      // VLAN: both end indexes plus random ones
      for (int i = 0; i < 4; i++) begin
         vlan_identifier[i] = (i == 0) ? 12'h000 : (i == 3) ? 12'hFFF : 12'(rnd());
         for (int j = 0; j < 3; j++) begin
            ve[i][j] = rnd();
            wr(12'h400 + 12'(4 * j), ve[i][j]);
         end
         wr(12'h40C, 32'(vlan_identifier[i]));
         wr(12'h410, 32'h80);
         poll(12'h410, 7, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         wr(12'h40C, 32'(vlan_identifier[i]));
         wr(12'h410, 32'h81);
         poll(12'h410, 7, 1'b0);
         rd(12'h400, ve[i][0], 32'hFF7F, 1'b0);
         rd(12'h404, ve[i][1], 32'h7, 1'b0);
         rd(12'h408, ve[i][2], 32'h7, 1'b0);
      end
      wr(12'h414, 32'h1);
      for (int i = 0; i < 4; i++) begin
         lookup_vid <= vlan_identifier[i];
         repeat (2) @(posedge clk);
         check(33'({lookup_entry.valid, lookup_entry.fwd_option, lookup_entry.filter_group_id,
                    lookup_entry.untag_mask[2:0], lookup_entry.member_mask[2:0]}),
               33'({ve[i][0][15:14], ve[i][0][6:0], ve[i][1][2:0], ve[i][2][2:0]}));
         check(33'({lookup_entry.priority_val, lookup_entry.spanning_tree_index}),
               33'({ve[i][0][10:8], ve[i][0][13:11]}));
      end
      // ACL: same index on every port keeps the tables apart
      for (int p = 0; p < 3; p++) begin
         wr(12'h648, 32'(p));
         for (int k = 0; k < 16; k++) begin
            acl[p][k] = 8'(rnd());
            if (k == 1) acl[p][k][5:4] = 2'b10;
            wr(12'h600 + 12'(4 * k), 32'(acl[p][k]));
         end
         wr(12'h640, 32'hFFFF);
         wr(12'h644, 32'h19);
         poll(12'h644, 6, 1'b1);
      end
      // Enables for byte F and the unused byte C only
      wr(12'h648, 32'h1);
      for (int k = 0; k < 16; k++) wr(12'h600 + 12'(4 * k), 32'(~acl[1][k]));
      wr(12'h640, 32'h9);
      wr(12'h644, 32'h19);
      poll(12'h644, 6, 1'b1);
      acl[1][15] = ~acl[1][15];
      wr(12'h640, 32'hFFFF);
      for (int p = 0; p < 3; p++) begin
         wr(12'h648, 32'(p));
         wr(12'h644, 32'h9);
         poll(12'h644, 5, 1'b1);
         for (int k = 0; k < 16; k++) rd(12'h600 + 12'(4 * k), 32'(acl[p][k]), 32'(BMSK[k]), 1'b0);
      end
      results();
   end
endmodule : switch_lookup_table_access_test
